/* logic/plm_pkg.sv */
package plm_pkg;

  // clock and filter timing
  localparam int CLK_MHZ = 100;
  localparam int CNT_W = 27; // wide enough for the one-second recovery delay
  localparam int THERM_FILT_US = 10;
  localparam int VCC_FILT_US = 10;
  localparam int EXT_HI_100K_US = 35;
  localparam logic [CNT_W-1:0] THERM_FILT_CYC = CNT_W'(THERM_FILT_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] VCC_FILT_CYC = CNT_W'(VCC_FILT_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] EXT_HI_100K_CYC = CNT_W'(EXT_HI_100K_US * CLK_MHZ);

  // filter slots
  localparam int N_FILT = 8;
  localparam int F_HI = 0;
  localparam int F_LO = 1;
  localparam int F_UV = 2;
  localparam int F_OV = 3;
  localparam int F_THERM = 4;
  localparam int F_FLT = 5;
  localparam int F_OFF = 6;
  localparam int F_REC = 7;

  // cause bits, one per latching or stopping event
  localparam int C_HI = 0;
  localparam int C_LO = 1;
  localparam int C_OVP = 2;
  localparam int C_TMR = 3;
  localparam int C_WS = 4;
  localparam int C_UV = 5;
  localparam int C_THERM = 6;
  localparam int C_OFF = 7;

  // register map
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STAT_OFS = 12'h004;
  localparam logic CTRL_RUN_RST = 1'h1;
  localparam int STAT_STATE_POS = 0;
  localparam int STAT_CAUSE_POS = 4;
  localparam int STAT_AUTOREC_POS = 12;
  localparam int STAT_100K_POS = 13;

  typedef enum logic [2:0] {
    ST_WAIT = 3'h0,
    ST_RUN = 3'h1,
    ST_LATCH = 3'h3,
    ST_AUTOREC = 3'h2,
    ST_STOP = 3'h6,
    ST_THERM = 3'h7,
    ST_OFFM = 3'h5
  } pm_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

endpackage

/* logic/event_filter.sv */
`timescale 1ns/1ns
`default_nettype none
module event_filter #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // condition and length
  input wire logic cond_i,
  input wire logic [W-1:0] dur_i,
  // filtered event
  output logic hit_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } filt_t;

  filt_t st;
  filt_t next_st;

  // count up while the condition holds, saturate at the length
  always_comb begin
    next_st = st;
    if (!cond_i) begin
      next_st.cnt = '0;
    end else if (st.cnt != dur_i) begin
      next_st.cnt = st.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // zero length would fire at once, so it never fires
  assign hit_o = (st.cnt == dur_i) && (dur_i != '0);

  chk_filt_restart: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !cond_i |=> st.cnt == '0) else $error("filter kept counting after drop");
  chk_filt_count: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    hit_o |-> $past(cond_i)) else $error("filter fired without held condition");

endmodule
`default_nettype wire

/* logic/apb_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module apb_regs (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // apb port
  input wire plm_pkg::apb_req_t apb_req_i,
  output plm_pkg::apb_rsp_t apb_rsp_o,
  // block side
  input wire logic [31:0] status_i,
  output logic run_enable_o
);
  import plm_pkg::*;

  typedef struct packed {
    apb_rsp_t rsp;
    logic run_en;
  } regs_t;

  regs_t st;
  regs_t next_st;

  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    is_reg = (a == ofs);
  endfunction

  // answer in the first access cycle; read data sampled at setup
  always_comb begin
    next_st = st;
    if (apb_req_i.psel && !apb_req_i.penable) begin
      next_st.rsp.pready = 1'h1;
      next_st.rsp.pslverr = !(is_reg(apb_req_i.paddr, CTRL_OFS) ||
                              is_reg(apb_req_i.paddr, STAT_OFS));
      if (is_reg(apb_req_i.paddr, CTRL_OFS)) begin
        next_st.rsp.prdata = {31'h0, st.run_en};
      end else if (is_reg(apb_req_i.paddr, STAT_OFS)) begin
        next_st.rsp.prdata = status_i;
      end else begin
        next_st.rsp.prdata = 32'h0;
      end
    end else if (apb_req_i.psel && apb_req_i.penable && st.rsp.pready) begin
      next_st.rsp = '0;
      if (apb_req_i.pwrite && is_reg(apb_req_i.paddr, CTRL_OFS)) begin
        next_st.run_en = apb_req_i.pwdata[0];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st.rsp <= '0;
      st.run_en <= CTRL_RUN_RST;
    end else begin
      st <= next_st;
    end
  end

  assign apb_rsp_o = st.rsp;
  assign run_enable_o = st.run_en;

endmodule
`default_nettype wire

/* logic/protection_latch_manager.sv */
`timescale 1ns/1ns
`default_nettype none
// How it works
// - latch off when window pin leaves window
// - blank short high and low excursions
// - latch cleared only by brown-out, thermal trip or reset
// - ignore latch comparators before ready
// - check high latch at turn-on, gate start
// - low latch checked after soft-start only
// - doubled thermistor bias during soft-start
// - thermal trip stops drive, keeps supply
// - thermal clear restarts through normal start
// - filtered thermal stop, release needs three
// - external window event filtered, then latched
// - timer faults release by auto-recovery option
// - off mode after long feedback low
// - winding short stops with no filter, latches unless auto-recovery
// - fault timer restarts when limit clears
// - auto-recovery retries after recovery delay
module protection_latch_manager #(
  parameter int EXT_HI_65K_US = 55,
  parameter int LATCH_LO_US = 350,
  parameter int FAULT_MS = 128,
  parameter int AUTOREC_MS = 1000,
  parameter int OFF_MODE_MS = 150
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // static options
  input wire logic opt_autorec_i,
  input wire logic opt_100k_i,
  // supply and line comparators
  input wire logic vcc_above_on_i,
  input wire logic vcc_below_uv_i,
  input wire logic vcc_below_reset_i,
  input wire logic vcc_above_ovp_i,
  input wire logic line_above_start_i,
  input wire logic brown_out_i,
  // latch pin window comparators
  input wire logic latch_high_i,
  input wire logic latch_low_i,
  // thermal, feedback, current sense
  input wire logic thermal_shutdown_i,
  input wire logic thermal_shutdown_clear_i,
  input wire logic fb_below_off_i,
  input wire logic fb_above_on_i,
  input wire logic cs_at_limit_i,
  input wire logic max_on_time_i,
  input wire logic winding_short_i,
  input wire logic soft_start_done_i,
  // register bus
  input wire plm_pkg::apb_req_t apb_req_i,
  output plm_pkg::apb_rsp_t apb_rsp_o,
  // power stage controls
  output logic gate_drive_out_o,
  output logic hv_source_en_o,
  output logic internal_supply_en_o,
  output logic thermistor_bias_boosted_o
);
  import plm_pkg::*;

  localparam logic [CNT_W-1:0] EXT_HI_65K_CYC = CNT_W'(EXT_HI_65K_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] LATCH_LO_CYC = CNT_W'(LATCH_LO_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] FAULT_CYC = CNT_W'(FAULT_MS * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] AUTOREC_CYC = CNT_W'(AUTOREC_MS * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] OFF_MODE_CYC = CNT_W'(OFF_MODE_MS * 1000 * CLK_MHZ);

  typedef struct packed {
    pm_state_t state;
    logic [7:0] cause;
    logic opt_autorec;
    logic opt_100k;
    logic drive;
    logic hv_en;
    logic supply_en;
    logic boost;
  } plm_t;

  plm_t st;
  plm_t next_st;
  logic [N_FILT-1:0] arm;
  logic [N_FILT-1:0] cond;
  logic [N_FILT-1:0] hit;
  logic [CNT_W-1:0] dur [N_FILT];
  logic run_enable;
  logic in_run;
  logic in_wait;

  assign in_run = (st.state == ST_RUN);
  assign in_wait = (st.state == ST_WAIT);

  // window comparators are blind until turn-on and soft-start
  always_comb begin
    arm = '0;
    arm[F_HI] = (in_wait && vcc_above_on_i) || in_run;
    arm[F_LO] = in_run && soft_start_done_i;
    arm[F_UV] = in_run;
    arm[F_OV] = in_run;
    arm[F_THERM] = 1'h1;
    arm[F_FLT] = in_run;
    arm[F_OFF] = in_run;
    arm[F_REC] = (st.state == ST_AUTOREC);
  end

  assign cond[F_HI] = arm[F_HI] && latch_high_i;
  assign cond[F_LO] = arm[F_LO] && latch_low_i;
  assign cond[F_UV] = arm[F_UV] && vcc_below_uv_i;
  assign cond[F_OV] = arm[F_OV] && vcc_above_ovp_i;
  assign cond[F_THERM] = arm[F_THERM] && thermal_shutdown_i;
  assign cond[F_FLT] = arm[F_FLT] && (cs_at_limit_i || max_on_time_i);
  assign cond[F_OFF] = arm[F_OFF] && fb_below_off_i;
  assign cond[F_REC] = arm[F_REC];

  // filter lengths; the high window edge follows the frequency option
  assign dur[F_HI] = st.opt_100k ? EXT_HI_100K_CYC : EXT_HI_65K_CYC;
  assign dur[F_LO] = LATCH_LO_CYC;
  assign dur[F_UV] = VCC_FILT_CYC;
  assign dur[F_OV] = VCC_FILT_CYC;
  assign dur[F_THERM] = THERM_FILT_CYC;
  assign dur[F_FLT] = FAULT_CYC;
  assign dur[F_OFF] = OFF_MODE_CYC;
  assign dur[F_REC] = AUTOREC_CYC;

  genvar gi;
  generate
    for (gi = 0; gi < N_FILT; gi++) begin : g_filt
      event_filter #(.W(CNT_W)) u_filt (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .cond_i(cond[gi]),
        .dur_i(dur[gi]),
        .hit_o(hit[gi])
      );
    end
  endgenerate

  apb_regs u_regs (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .apb_req_i(apb_req_i),
    .apb_rsp_o(apb_rsp_o),
    .status_i({18'h0, st.opt_100k, st.opt_autorec, st.cause, 1'h0, st.state}),
    .run_enable_o(run_enable)
  );

  // state walk; later overrides have the higher priority
  always_comb begin
    next_st = st;
    unique case (st.state)
      ST_WAIT: begin
        if (hit[F_HI]) begin
          next_st.state = ST_LATCH;
          next_st.cause = 8'h1 << C_HI;
        end else if (run_enable && vcc_above_on_i && line_above_start_i &&
                     !latch_high_i) begin
          next_st.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (hit[F_HI] || hit[F_LO] || hit[F_OV]) begin
          next_st.state = ST_LATCH;
          next_st.cause = 8'h0;
          next_st.cause[C_HI] = hit[F_HI];
          next_st.cause[C_LO] = hit[F_LO];
          next_st.cause[C_OVP] = hit[F_OV];
        end else if (winding_short_i || hit[F_FLT] || hit[F_UV]) begin
          // timer faults may recover on their own
          next_st.state = st.opt_autorec ? ST_AUTOREC : ST_LATCH;
          next_st.cause = 8'h0;
          next_st.cause[C_WS] = winding_short_i;
          next_st.cause[C_TMR] = hit[F_FLT];
          next_st.cause[C_UV] = hit[F_UV];
        end else if (hit[F_OFF]) begin
          next_st.state = ST_OFFM;
          next_st.cause = 8'h1 << C_OFF;
        end
      end
      ST_LATCH: begin
        next_st.state = ST_LATCH;
      end
      ST_AUTOREC: begin
        if (hit[F_REC]) begin
          next_st.state = ST_WAIT;
        end
      end
      ST_STOP: begin
        if (line_above_start_i && vcc_above_on_i) begin
          next_st.state = ST_WAIT;
        end
      end
      ST_THERM: begin
        if (line_above_start_i && vcc_above_on_i && thermal_shutdown_clear_i) begin
          next_st.state = ST_WAIT;
        end
      end
      ST_OFFM: begin
        if (line_above_start_i && vcc_above_on_i && fb_above_on_i) begin
          next_st.state = ST_WAIT;
        end
      end
      default: begin
        next_st.state = ST_WAIT;
      end
    endcase
    // brown-out clears any latch; thermal and off states keep their info
    if (brown_out_i && st.state != ST_THERM && st.state != ST_OFFM) begin
      next_st.state = ST_STOP;
    end
    if (hit[F_THERM]) begin
      next_st.state = ST_THERM;
      next_st.cause = 8'h1 << C_THERM;
    end
    if (vcc_below_reset_i) begin
      next_st.state = ST_WAIT;
    end
    // outputs registered from the next state, so they move with it
    next_st.drive = (next_st.state == ST_RUN);
    next_st.hv_en = (next_st.state != ST_THERM);
    next_st.supply_en = (next_st.state != ST_OFFM);
    next_st.boost = (next_st.state == ST_RUN) && !soft_start_done_i;
  end

  // options are straps: taken while reset is held, frozen after
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.state <= ST_WAIT;
      st.hv_en <= 1'h1;
      st.supply_en <= 1'h1;
      st.opt_autorec <= opt_autorec_i;
      st.opt_100k <= opt_100k_i;
    end else begin
      st <= next_st;
    end
  end

  assign gate_drive_out_o = st.drive;
  assign hv_source_en_o = st.hv_en;
  assign internal_supply_en_o = st.supply_en;
  assign thermistor_bias_boosted_o = st.boost;

  // helper run-length counters of the armed window comparator conditions
  logic [CNT_W-1:0] hi_run;
  logic [CNT_W-1:0] lo_run;
  logic preempt;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      hi_run <= '0;
      lo_run <= '0;
    end else begin
      hi_run <= cond[F_HI] ? hi_run + CNT_W'(1) : '0;
      lo_run <= cond[F_LO] ? lo_run + CNT_W'(1) : '0;
    end
  end
  assign preempt = vcc_below_reset_i || brown_out_i || hit[F_THERM];

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_window_latch: assert property (in_run && (hit[F_HI] || hit[F_LO]) && !preempt
    |=> st.state == ST_LATCH) else $error("window event did not latch");
  chk_window_blank: assert property ($rose(st.state == ST_LATCH) && st.cause[C_HI]
    |-> $past(hi_run) >= dur[F_HI]) else $error("short high excursion latched");
  chk_low_blank: assert property ($rose(st.state == ST_LATCH) && st.cause[C_LO]
    |-> $past(lo_run) >= LATCH_LO_CYC) else $error("short low excursion latched");
  chk_latch_hold: assert property (st.state == ST_LATCH && !preempt
    |=> st.state == ST_LATCH) else $error("latch left without release");
  chk_start_blind: assert property (in_wait && !vcc_above_on_i
    |-> !arm[F_HI] && !arm[F_LO]) else $error("window watched before turn-on");
  chk_start_gate: assert property ($rose(st.state == ST_RUN)
    |-> !$past(latch_high_i) && $past(vcc_above_on_i))
    else $error("drive began under high latch");
  chk_low_arm: assert property (arm[F_LO]
    |-> soft_start_done_i && in_run) else $error("low latch watched in soft-start");
  chk_bias_boost: assert property (thermistor_bias_boosted_o
    |-> gate_drive_out_o && !$past(soft_start_done_i)) else $error("bias boost misplaced");
  chk_therm_stop: assert property (hit[F_THERM] && !vcc_below_reset_i
    |=> !gate_drive_out_o && !hv_source_en_o && internal_supply_en_o)
    else $error("thermal trip did not stop drive");
  chk_therm_release: assert property (st.state == ST_THERM && !preempt
    && !thermal_shutdown_clear_i
    |=> st.state == ST_THERM) else $error("thermal state left while hot");
  chk_ws_immediate: assert property (in_run && winding_short_i && !preempt
    |=> st.state inside {ST_LATCH, ST_AUTOREC}) else $error("winding short not caught");
  chk_autorec_opt: assert property ($rose(st.state == ST_AUTOREC)
    |-> st.opt_autorec) else $error("recovery without option");
  chk_autorec_retry: assert property (st.state == ST_AUTOREC && hit[F_REC] && !preempt
    |=> in_wait) else $error("recovery delay did not retry");
  chk_off_supply: assert property (st.state == ST_OFFM
    |-> !internal_supply_en_o && !gate_drive_out_o) else $error("off mode kept supply");
  chk_opt_static: assert property ($stable(st.opt_autorec) && $stable(st.opt_100k))
    else $error("options changed after power-up");

  cov_run: cover property ($rose(st.state == ST_RUN));
  cov_latch: cover property ($rose(st.state == ST_LATCH));
  cov_retry: cover property (st.state == ST_AUTOREC ##1 in_wait);
  cov_therm: cover property ($rose(st.state == ST_THERM));

endmodule
`default_nettype wire

/* tb/thermal_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
module thermal_pin_model #(
  parameter int SS_CYC = 400
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // power switch drive from the block
  input wire logic gate_drive_out_i,
  // thermistor and overvoltage sensing conditions
  input wire logic hot_i,
  input wire logic ovp_i,
  // comparator and soft-start answers
  output logic latch_low_o,
  output logic latch_high_o,
  output logic soft_start_done_o
);
  int unsigned ss_cnt;

  // soft-start restarts on every stop, so a restart always ramps again
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !gate_drive_out_i) begin
      ss_cnt <= 0;
    end else if (ss_cnt < SS_CYC) begin
      ss_cnt <= ss_cnt + 1;
    end
  end

  // window comparators follow the sensed conditions directly
  assign soft_start_done_o = (ss_cnt == SS_CYC);
  assign latch_low_o = hot_i;
  assign latch_high_o = ovp_i;
endmodule
`default_nettype wire

/* tb/protection_latch_manager_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module protection_latch_manager_bench;
  import plm_pkg::*;
  localparam int L_WIN = 100; // 1 us window filters at 100 MHz
  logic clk_sys_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic [1:0] opt = 2'h0;
  logic [4:0] fault = 5'h0; // window high, window low, ovp, uv, winding short
  logic vcc_on = 1'h0, vcc_rst = 1'h0, line_ok = 1'h0, brown = 1'h0;
  logic therm = 1'h0, therm_clr = 1'h0;
  logic cs_lim = 1'h0, max_on = 1'h0, fb_off = 1'h0, fb_on = 1'h0;
  logic lo, hi, ss_done, gate, hv, sup, boost, err;
  logic [31:0] rd;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  int n_errors = 0;
  int comparisons = 0;
  int flen[5] = '{L_WIN, L_WIN, 1000, 1000, 1};
  int cbit[5] = '{C_HI, C_LO, C_OVP, C_UV, C_WS};

  always #5 clk_sys_i = ~clk_sys_i;

  thermal_pin_model #(.SS_CYC(400)) partner (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .gate_drive_out_i(gate), .hot_i(fault[1]), .ovp_i(fault[0]), .latch_low_o(lo),
    .latch_high_o(hi), .soft_start_done_o(ss_done));

  // short filter parameters keep the run brief
  protection_latch_manager #(.EXT_HI_65K_US(1), .LATCH_LO_US(1), .FAULT_MS(1),
    .AUTOREC_MS(1), .OFF_MODE_MS(1)) DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .opt_autorec_i(opt[0]), .opt_100k_i(opt[1]), .vcc_above_on_i(vcc_on),
    .vcc_below_uv_i(fault[3]), .vcc_below_reset_i(vcc_rst), .vcc_above_ovp_i(fault[2]),
    .line_above_start_i(line_ok), .brown_out_i(brown), .latch_high_i(hi), .latch_low_i(lo),
    .thermal_shutdown_i(therm), .thermal_shutdown_clear_i(therm_clr), .fb_below_off_i(fb_off),
    .fb_above_on_i(fb_on), .cs_at_limit_i(cs_lim), .max_on_time_i(max_on),
    .winding_short_i(fault[4]), .soft_start_done_i(ss_done), .apb_req_i(req),
    .apb_rsp_o(rsp), .gate_drive_out_o(gate), .hv_source_en_o(hv),
    .internal_supply_en_o(sup), .thermistor_bias_boosted_o(boost));

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // one apb transfer; waits for pready rather than assuming a latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys_i);
    req.penable <= 1'h1;
    @(posedge clk_sys_i);
    while (rsp.pready !== 1'h1 && n < 20) begin
      n++;
      @(posedge clk_sys_i);
    end
    chk("pready", {31'h0, rsp.pready}, 32'h1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic stat(input logic [2:0] st, input logic [7:0] cause, input bit cc);
    apb(1'h0, STAT_OFS, 32'h0);
    chk("state", {29'h0, rd[2:0]}, {29'h0, st});
    if (cc) chk("cause", {24'h0, rd[11:4]}, {24'h0, cause});
  endtask

  task automatic wait_gate(input logic v);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    while (gate !== v && n < 3000) begin
      n++;
      @(negedge clk_sys_i);
    end
    chk("gate", {31'h0, gate}, {31'h0, v});
  endtask

  task automatic bring_up();
    tick(1);
    vcc_on <= 1'h1;
    line_ok <= 1'h1;
    wait_gate(1'h1);
    chk("boost", {31'h0, boost}, 32'h1);
    tick(420);
    @(negedge clk_sys_i);
    chk("boost", {31'h0, boost}, 32'h0);
  endtask

  // the cause field keeps the last entry across a supply reset
  task automatic supply_reset(input logic [7:0] cause);
    tick(1);
    vcc_rst <= 1'h1;
    vcc_on <= 1'h0;
    tick(2);
    vcc_rst <= 1'h0;
    stat(ST_WAIT, cause, 1);
  endtask

  // a hang counts as a mismatch and ends through the same verdict
  initial begin
    tick(60000);
    n_errors++;
    give_verdict();
  end

  initial begin
    tick(8);
    sys_rst_i <= 1'h0;
    @(negedge clk_sys_i);
    chk("drive", {29'h0, gate, hv, sup}, 32'h3);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk("ctrl", rd, 32'h1);
    apb(1'h0, STAT_OFS, 32'h0);
    chk("status", rd, 32'h0);
    // high window before turn-on is ignored, at turn-on it holds off start
    fault[0] <= 1'h1;
    tick(300);
    vcc_on <= 1'h1;
    line_ok <= 1'h1;
    tick(20);
    @(negedge clk_sys_i);
    chk("gate", {31'h0, gate}, 32'h0);
    tick(1);
    fault[0] <= 1'h0;
    fault[1] <= 1'h1;
    wait_gate(1'h1);
    // low window waits for soft-start, then latches
    tick(200);
    @(negedge clk_sys_i);
    chk("ss_run", {30'h0, gate, boost}, 32'h3);
    tick(400);
    @(negedge clk_sys_i);
    chk("gate", {31'h0, gate}, 32'h0);
    tick(1);
    fault[1] <= 1'h0;
    supply_reset(8'h1 << C_LO);
    bring_up();
    // each latching fault: a short pulse is blanked (not for winding short), a long one latches
    for (int i = 0; i < 5; i++) begin
      if (flen[i] > 1) begin
        tick(1);
        fault[i] <= 1'h1;
        tick(flen[i] - 1);
        fault[i] <= 1'h0;
        tick(4);
        @(negedge clk_sys_i);
        chk("blank", {31'h0, gate}, 32'h1);
      end
      tick(1);
      fault[i] <= 1'h1;
      tick(flen[i] + 2);
      @(negedge clk_sys_i);
      chk("trip", {31'h0, gate}, 32'h0);
      tick(1);
      fault[i] <= 1'h0;
      stat(ST_LATCH, 8'h1 << cbit[i], 1);
      tick(50);
      @(negedge clk_sys_i);
      chk("held", {31'h0, gate}, 32'h0);
      if (i % 2 == 1) begin
        tick(1);
        brown <= 1'h1;
        line_ok <= 1'h0;
        tick(4);
        stat(ST_STOP, 8'h0, 0);
        brown <= 1'h0;
      end else begin
        supply_reset(8'h1 << cbit[i]);
      end
      bring_up();
    end
    // thermal stop keeps the supply, restarts only once cleared
    tick(1);
    therm <= 1'h1;
    tick(1003);
    @(negedge clk_sys_i);
    chk("thermal", {29'h0, gate, hv, sup}, 32'h1);
    tick(1);
    therm <= 1'h0;
    stat(ST_THERM, 8'h1 << C_THERM, 1);
    therm_clr <= 1'h1;
    wait_gate(1'h1);
    chk("boost", {31'h0, boost}, 32'h1);
    tick(1);
    therm_clr <= 1'h0;
    // run enable off holds the device idle; unmapped and read-only places
    apb(1'h1, CTRL_OFS, 32'h0);
    supply_reset(8'h1 << C_THERM);
    vcc_on <= 1'h1;
    tick(30);
    @(negedge clk_sys_i);
    chk("gate", {31'h0, gate}, 32'h0);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk("ctrl", rd, 32'h0);
    apb(1'h1, STAT_OFS, 32'hffffffff);
    apb(1'h0, 12'h008, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    apb(1'h1, CTRL_OFS, 32'h1);
    wait_gate(1'h1);
    stat(ST_RUN, 8'h0, 0);
    // short fault-timer and off-mode conditions only restart their filters
    tick(1);
    {cs_lim, max_on, fb_off} <= 3'h7;
    tick(200);
    {cs_lim, max_on, fb_off, fb_on} <= 4'h1;
    tick(4);
    @(negedge clk_sys_i);
    chk("timer", {31'h0, gate}, 32'h1);
    // second reset with both straps set: recovery option, 100 kHz lengths
    tick(1);
    sys_rst_i <= 1'h1;
    opt <= 2'h3;
    vcc_on <= 1'h0;
    tick(8);
    sys_rst_i <= 1'h0;
    stat(ST_WAIT, 8'h0, 1);
    chk("straps", rd, 32'h3000);
    bring_up();
    tick(1);
    fault[0] <= 1'h1;
    tick(int'(EXT_HI_100K_CYC) - 1);
    fault[0] <= 1'h0;
    tick(4);
    @(negedge clk_sys_i);
    chk("blank_100k", {31'h0, gate}, 32'h1);
    tick(1);
    fault[0] <= 1'h1;
    tick(int'(EXT_HI_100K_CYC) + 2);
    @(negedge clk_sys_i);
    chk("trip_100k", {31'h0, gate}, 32'h0);
    tick(1);
    fault[0] <= 1'h0;
    supply_reset(8'h1 << C_HI);
    bring_up();
    tick(1);
    fault[4] <= 1'h1;
    tick(3);
    @(negedge clk_sys_i);
    chk("ws_recover", {31'h0, gate}, 32'h0);
    tick(1);
    fault[4] <= 1'h0;
    stat(ST_AUTOREC, 8'h1 << C_WS, 1);
    give_verdict();
  end
endmodule
`default_nettype wire
